// >>> rtl/dsp_decode_pkg.sv
// Purpose: shared constants and types for the accumulator and
//          auxiliary-register instruction decoder.
// Assumes: 16-bit instruction words, 32-bit APB data.
// Notes:   none

package dsp_decode_pkg;

    // ----------------------------------------
    // Decoded operations
    // ----------------------------------------
    typedef enum logic [4:0] {
        OP_OTHER, OP_ADD, OP_SUB, OP_LOAD_ACC_SHIFTED,
        OP_ADD_HIGH_HALF, OP_ADD_UNSIGNED_EXT,
        OP_SUBTRACT_HIGH_HALF, OP_SUBTRACT_UNSIGNED_EXT,
        OP_CONDITIONAL_SUBTRACT, OP_CLEAR_LOAD_HIGH,
        OP_CLEAR_LOAD_LOW, OP_XOR, OP_AND, OP_OR, OP_ABS,
        OP_CLEAR_ACC, OP_LOAD_ACC_IMMEDIATE, OP_STORE_ACC_HIGH,
        OP_STORE_ACC_LOW, OP_LOAD_AUX_REG, OP_STORE_AUX_REG,
        OP_LOAD_AUX_IMMEDIATE, OP_LOAD_AUX_POINTER,
        OP_LOAD_PAGE_IMMEDIATE, OP_MODIFY_AUX_REG,
        OP_LOAD_PAGE_POINTER
    } op_e;

    // ----------------------------------------
    // APB register offsets and reset values
    // ----------------------------------------
    localparam logic [11:0] OFF_AUX0 = 12'h000;
    localparam logic [11:0] OFF_AUX1 = 12'h004;
    localparam logic [11:0] OFF_PTRS = 12'h008;
    localparam logic [11:0] OFF_LAST = 12'h00c;
    localparam logic [15:0] AUX_RST = 16'h0000;
    localparam logic ARP_RST = 1'b0;
    localparam logic DP_RST = 1'b0;

    // ----------------------------------------
    // Instruction field positions
    // ----------------------------------------
    localparam int MODE_BIT = 7;
    localparam int INC_BIT = 5;
    localparam int DEC_BIT = 4;
    localparam int KEEP_ARP_BIT = 3;
    localparam int RSEL_BIT = 8;
    localparam int SHIFT_W = 4;
    localparam int STSHIFT_W = 3;
    localparam int PORT_W = 3;
    localparam int ACC_HIGH_LSB = 16;
    localparam int ACC_LOW_MSB = 15;

    // ----------------------------------------
    // Opcode patterns
    // ----------------------------------------
    localparam logic [3:0] NIB_ADD = 4'h0;
    localparam logic [3:0] NIB_SUB = 4'h1;
    localparam logic [3:0] NIB_LAC = 4'h2;
    localparam logic [7:0] BYTE_ADD_HIGH_HALF = 8'h60;
    localparam logic [7:0] BYTE_ADD_UNSIGNED_EXT = 8'h61;
    localparam logic [7:0] BYTE_SUBTRACT_HIGH_HALF = 8'h62;
    localparam logic [7:0] BYTE_SUBTRACT_UNSIGNED_EXT = 8'h63;
    localparam logic [7:0] BYTE_CSUB = 8'h64;
    localparam logic [7:0] BYTE_ZLH = 8'h65;
    localparam logic [7:0] BYTE_ZLL = 8'h66;
    localparam logic [7:0] BYTE_MODAUX = 8'h68;
    localparam logic [7:0] BYTE_LDPG = 8'h6f;
    localparam logic [7:0] BYTE_XOR = 8'h78;
    localparam logic [7:0] BYTE_AND = 8'h79;
    localparam logic [7:0] BYTE_OR = 8'h7a;
    localparam logic [7:0] BYTE_LACC_IMM = 8'h7e;
    localparam logic [7:0] BYTE_STLOW = 8'h50;
    localparam logic [4:0] TOP_STHIGH = 5'h0b;
    localparam logic [6:0] TOP_LDAUX = 7'h1c;
    localparam logic [6:0] TOP_STAUX = 7'h18;
    localparam logic [6:0] TOP_LDAUX_IMM = 7'h38;
    localparam logic [14:0] TOP_LDARP = 15'h3440;
    localparam logic [14:0] TOP_LDPG_IMM = 15'h3700;
    localparam logic [15:0] WORD_ABS = 16'h7f88;
    localparam logic [15:0] WORD_CLR = 16'h7f89;

    // ----------------------------------------
    // Cycle and word counts
    // ----------------------------------------
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] WORDS_ONE = 2'h1;
    localparam logic [1:0] CNT_NONE = 2'h0;

endpackage

// >>> rtl/dsp_accum_auxreg_decoder.sv
// Purpose: decode accumulator and aux-register instructions and
//          generate the data memory operand address.
// Assumes: one instruction per instrValid cycle; memory reads for
//          aux/page loads return on operandValid.
// Notes:   all outputs registered; APB gives access to pointers.
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ps

module dsp_accum_auxreg_decoder
    import dsp_decode_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Instruction in
    input wire logic instrValid,
    input wire logic [15:0] instrWord,
    // Operand returned for aux and page loads
    input wire logic operandValid,
    input wire logic [15:0] operandData,
    // Decoded instruction out
    output logic decValid,
    output dsp_decode_pkg::op_e decOp,
    output logic [7:0] dataAddr,
    output logic memRead,
    output logic memWrite,
    output logic indirectMode,
    output logic [dsp_decode_pkg::SHIFT_W-1:0] shiftCode,
    output logic [dsp_decode_pkg::STSHIFT_W-1:0] storeShift,
    output logic [dsp_decode_pkg::PORT_W-1:0] portAddr,
    output logic [7:0] immValue,
    output logic unsignedExt,
    output logic accHigh,
    output logic accLow,
    output logic [15:0] storeAuxData,
    output logic [1:0] cycleCount,
    output logic [1:0] wordCount,
    // Words for other decoders
    output logic otherValid,
    output logic [15:0] otherWord,
    // Pointer state
    output logic auxPointer,
    output logic pagePointer,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    import dsp_decode_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [15:0] auxReg_ff [2]; // Aux registers zero and one
    logic auxPtr_ff; // Selects current aux register
    logic pagePtr_ff; // Data page bit
    logic [1:0] loadTgt_ff; // Pending memory load target
    logic [15:0] lastWord_ff; // Last decoded word
    op_e lastOp_ff; // Last decoded operation
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;

    // Pending load targets
    localparam logic [1:0] TGT_NONE = 2'h0;
    localparam logic [1:0] TGT_AUX0 = 2'h1;
    localparam logic [1:0] TGT_AUX1 = 2'h2;
    localparam logic [1:0] TGT_PAGE = 2'h3;

    // ----------------------------------------
    // Pattern match
    // ----------------------------------------
    logic [15:0] w;
    op_e nxt_op;
    assign w = instrWord;

    // Exact words first, then 15-bit prefixes, then nibbles before 5- and 7-bit prefixes
    always_comb
    begin
        nxt_op = OP_OTHER;
        if (w == WORD_ABS)
            nxt_op = OP_ABS;
        else if (w == WORD_CLR)
            nxt_op = OP_CLEAR_ACC;
        else if (w[15:1] == TOP_LDARP)
            nxt_op = OP_LOAD_AUX_POINTER;
        else if (w[15:1] == TOP_LDPG_IMM)
            nxt_op = OP_LOAD_PAGE_IMMEDIATE;
        else if (w[15:12] == NIB_ADD)
            nxt_op = OP_ADD;
        else if (w[15:12] == NIB_SUB)
            nxt_op = OP_SUB;
        else if (w[15:12] == NIB_LAC)
            nxt_op = OP_LOAD_ACC_SHIFTED;
        else if (w[15:11] == TOP_STHIGH)
            nxt_op = OP_STORE_ACC_HIGH;
        else if (w[15:9] == TOP_LDAUX)
            nxt_op = OP_LOAD_AUX_REG;
        else if (w[15:9] == TOP_STAUX)
            nxt_op = OP_STORE_AUX_REG;
        else if (w[15:9] == TOP_LDAUX_IMM)
            nxt_op = OP_LOAD_AUX_IMMEDIATE;
        else
        begin
            // Byte opcodes; anything else stays other-group
            case (w[15:8])
                BYTE_ADD_HIGH_HALF: nxt_op = OP_ADD_HIGH_HALF;
                BYTE_ADD_UNSIGNED_EXT: nxt_op = OP_ADD_UNSIGNED_EXT;
                BYTE_SUBTRACT_HIGH_HALF: nxt_op = OP_SUBTRACT_HIGH_HALF;
                BYTE_SUBTRACT_UNSIGNED_EXT: nxt_op = OP_SUBTRACT_UNSIGNED_EXT;
                BYTE_CSUB: nxt_op = OP_CONDITIONAL_SUBTRACT;
                BYTE_ZLH: nxt_op = OP_CLEAR_LOAD_HIGH;
                BYTE_ZLL: nxt_op = OP_CLEAR_LOAD_LOW;
                BYTE_XOR: nxt_op = OP_XOR;
                BYTE_AND: nxt_op = OP_AND;
                BYTE_OR: nxt_op = OP_OR;
                BYTE_LACC_IMM: nxt_op = OP_LOAD_ACC_IMMEDIATE;
                BYTE_STLOW: nxt_op = OP_STORE_ACC_LOW;
                BYTE_MODAUX: nxt_op = OP_MODIFY_AUX_REG;
                BYTE_LDPG: nxt_op = OP_LOAD_PAGE_POINTER;
                default: nxt_op = OP_OTHER;
            endcase
        end
    end

    // ----------------------------------------
    // Operation attributes
    // ----------------------------------------
    logic rd; // Reads data memory
    logic wr; // Writes data memory
    logic modOnly; // Address modify without access
    logic immed; // Operand in the word itself
    logic unsg; // No sign extension
    logic hi; // Targets high half
    logic lo; // Targets low half

    always_comb
    begin
        rd = 1'b0;
        wr = 1'b0;
        modOnly = 1'b0;
        immed = 1'b0;
        unsg = 1'b0;
        hi = 1'b0;
        lo = 1'b0;
        case (nxt_op)
            OP_ADD, OP_SUB, OP_LOAD_ACC_SHIFTED, OP_XOR, OP_AND,
            OP_OR, OP_CONDITIONAL_SUBTRACT, OP_LOAD_AUX_REG,
            OP_LOAD_PAGE_POINTER:
                rd = 1'b1;
            OP_ADD_HIGH_HALF, OP_SUBTRACT_HIGH_HALF,
            OP_CLEAR_LOAD_HIGH:
            begin
                rd = 1'b1;
                hi = 1'b1;
            end
            OP_ADD_UNSIGNED_EXT, OP_SUBTRACT_UNSIGNED_EXT:
            begin
                rd = 1'b1;
                unsg = 1'b1;
            end
            OP_CLEAR_LOAD_LOW:
            begin
                rd = 1'b1;
                unsg = 1'b1;
                lo = 1'b1;
            end
            OP_STORE_ACC_HIGH:
            begin
                wr = 1'b1;
                hi = 1'b1;
            end
            OP_STORE_ACC_LOW:
            begin
                wr = 1'b1;
                lo = 1'b1;
            end
            OP_STORE_AUX_REG:
                wr = 1'b1;
            OP_MODIFY_AUX_REG:
                modOnly = 1'b1;
            OP_LOAD_ACC_IMMEDIATE, OP_LOAD_AUX_IMMEDIATE:
                immed = 1'b1;
            default:
                rd = 1'b0; // No operand at all
        endcase
    end

    // ----------------------------------------
    // Address generation
    // ----------------------------------------
    logic useMem; // Has a data memory operand
    logic indir; // Indirect mode this word
    logic [15:0] selAux; // Currently selected aux
    logic [7:0] nxt_addr;
    logic step; // Indirect update applies
    logic apbWr; // APB write completes
    logic apbSetup;

    assign useMem = rd | wr | modOnly;
    // Immediate words never take bit 7 as a mode bit
    assign indir = useMem & ~immed & w[MODE_BIT];
    assign selAux = auxReg_ff[auxPtr_ff];
    assign nxt_addr = indir ? selAux[7:0]
                            : {pagePtr_ff, w[6:0]};
    assign step = instrValid & indir;
    assign apbSetup = psel & ~penable;
    assign apbWr = psel & penable & pwrite & pready_ff;

    // ----------------------------------------
    // Aux registers, one per entry
    // ----------------------------------------
    // A returning operand wins over a same-cycle step, because the
    // load was issued earlier and software expects its value
    generate
        for (genvar i = 0; i < 2; i++)
        begin : g_aux
            logic inc;
            logic dec;
            logic mine;
            logic [11:0] off;
            assign inc = w[INC_BIT] & ~w[DEC_BIT];
            assign dec = w[DEC_BIT] & ~w[INC_BIT];
            assign mine = (auxPtr_ff == 1'(i));
            assign off = (i == 0) ? OFF_AUX0 : OFF_AUX1;

            // Load, immediate load, step, then software write
            always_ff @(posedge clock or negedge rst_b)
            begin
                if (!rst_b)
                    auxReg_ff[i] <= AUX_RST;
                else if (operandValid && loadTgt_ff == 2'(i + 1))
                    auxReg_ff[i] <= operandData;
                else if (instrValid &&
                         nxt_op == OP_LOAD_AUX_IMMEDIATE &&
                         w[RSEL_BIT] == 1'(i))
                    auxReg_ff[i] <= {8'h00, w[7:0]};
                else if (step && mine && inc)
                    auxReg_ff[i] <= auxReg_ff[i] + 16'h0001;
                else if (step && mine && dec)
                    auxReg_ff[i] <= auxReg_ff[i] - 16'h0001;
                else if (apbWr && paddr == off)
                    auxReg_ff[i] <= pwdata[15:0];
            end
        end
    endgenerate

    // ----------------------------------------
    // Aux pointer
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            auxPtr_ff <= ARP_RST;
        else if (instrValid && nxt_op == OP_LOAD_AUX_POINTER)
            auxPtr_ff <= w[0];
        else if (step && !w[KEEP_ARP_BIT])
            auxPtr_ff <= w[0];
        else if (apbWr && paddr == OFF_PTRS)
            auxPtr_ff <= pwdata[0];
    end

    // ----------------------------------------
    // Data page pointer
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            pagePtr_ff <= DP_RST;
        else if (operandValid && loadTgt_ff == TGT_PAGE)
            pagePtr_ff <= operandData[0];
        else if (instrValid && nxt_op == OP_LOAD_PAGE_IMMEDIATE)
            pagePtr_ff <= w[0];
        else if (apbWr && paddr == OFF_PTRS)
            pagePtr_ff <= pwdata[1];
    end

    // ----------------------------------------
    // Pending memory load target
    // ----------------------------------------
    // Only one load tracked; a second issued before the first
    // returns replaces it
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            loadTgt_ff <= TGT_NONE;
        else if (instrValid && nxt_op == OP_LOAD_AUX_REG)
            loadTgt_ff <= w[RSEL_BIT] ? TGT_AUX1 : TGT_AUX0;
        else if (instrValid && nxt_op == OP_LOAD_PAGE_POINTER)
            loadTgt_ff <= TGT_PAGE;
        else if (operandValid)
            loadTgt_ff <= TGT_NONE;
    end

    // ----------------------------------------
    // Decoded outputs
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            decValid <= 1'b0;
            decOp <= OP_OTHER;
            dataAddr <= 8'h00;
            memRead <= 1'b0;
            memWrite <= 1'b0;
            indirectMode <= 1'b0;
            shiftCode <= 4'h0;
            storeShift <= 3'h0;
            portAddr <= 3'h0;
            immValue <= 8'h00;
            unsignedExt <= 1'b0;
            accHigh <= 1'b0;
            accLow <= 1'b0;
            storeAuxData <= 16'h0000;
            cycleCount <= CNT_NONE;
            wordCount <= CNT_NONE;
            otherValid <= 1'b0;
            otherWord <= 16'h0000;
        end
        else
        begin
            // Valid only for words this group owns
            decValid <= instrValid && nxt_op != OP_OTHER;
            otherValid <= instrValid && nxt_op == OP_OTHER;
            otherWord <= w;
            decOp <= nxt_op;
            dataAddr <= useMem ? nxt_addr : 8'h00;
            memRead <= instrValid & rd;
            memWrite <= instrValid & wr;
            indirectMode <= indir;
            shiftCode <= w[11:8];
            storeShift <= w[10:8];
            portAddr <= w[10:8];
            immValue <= w[7:0];
            unsignedExt <= unsg;
            accHigh <= hi;
            accLow <= lo;
            storeAuxData <= auxReg_ff[w[RSEL_BIT]];
            cycleCount <= (nxt_op == OP_OTHER) ? CNT_NONE : CYC_ONE;
            wordCount <= (nxt_op == OP_OTHER) ? CNT_NONE : WORDS_ONE;
        end
    end

    // Last decoded word, readable by software
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            lastWord_ff <= 16'h0000;
            lastOp_ff <= OP_OTHER;
        end
        else if (instrValid)
        begin
            lastWord_ff <= w;
            lastOp_ff <= nxt_op;
        end
    end

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    // Answer with one fixed access cycle; data latched at setup
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end
        else
        begin
            pready_ff <= apbSetup;
            if (apbSetup)
            begin
                pslverr_ff <= 1'b0;
                case (paddr)
                    OFF_AUX0: prdata_ff <= {16'h0000, auxReg_ff[0]};
                    OFF_AUX1: prdata_ff <= {16'h0000, auxReg_ff[1]};
                    OFF_PTRS:
                        prdata_ff <= {30'h0, pagePtr_ff, auxPtr_ff};
                    OFF_LAST:
                        prdata_ff <= {11'h0, lastOp_ff, lastWord_ff};
                    default:
                    begin
                        // Unmapped: error and zero data
                        prdata_ff <= 32'h0000_0000;
                        pslverr_ff <= 1'b1;
                    end
                endcase
            end
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign auxPointer = auxPtr_ff;
    assign pagePointer = pagePtr_ff;

endmodule // dsp_accum_auxreg_decoder

// >>> test/dsp_decoder_sva.sv
// Purpose: port checker for the accumulator and aux decoder
// Assumes: outputs registered one edge after instrValid
// Notes:   bound at the foot
`timescale 1ns/1ps

module dsp_decoder_sva
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Instruction in
    input wire logic instrValid,
    input wire logic [15:0] instrWord,
    // Decoder outputs
    input wire logic decValid,
    input wire logic otherValid,
    input wire dsp_decode_pkg::op_e decOp,
    input wire logic [7:0] dataAddr,
    input wire logic memRead,
    input wire logic memWrite,
    input wire logic indirectMode,
    input wire logic [dsp_decode_pkg::SHIFT_W-1:0] shiftCode,
    input wire logic [dsp_decode_pkg::STSHIFT_W-1:0] storeShift,
    input wire logic [7:0] immValue,
    input wire logic [1:0] cycleCount,
    input wire logic [1:0] wordCount,
    input wire logic auxPointer,
    input wire logic pagePointer
);
    import dsp_decode_pkg::*;

    // ----------------------------------------
    // Properties, all on the core clock
    // ----------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    a_quiet_idle:
    assert property (!instrValid |=> !decValid && !otherValid)
        else $error("answer without an instruction");
    a_one_answer:
    assert property (instrValid |=> decValid != otherValid)
        else $error("word not answered by exactly one path");
    a_direct_addr:
    assert property (instrValid && instrWord[15:12] == 4'h0 && !instrWord[7]
        |=> dataAddr == {$past(pagePointer), $past(instrWord[6:0])})
        else $error("direct address not page plus seven bits");
    a_ptr_change:
    assert property (instrValid && instrWord[15:13] == 3'h0 && instrWord[7]
        && !instrWord[3] |=> auxPointer == $past(instrWord[0]))
        else $error("pointer not changed with indirect step");
    a_imm_nomem:
    assert property (instrValid && instrWord[15:8] == 8'h7e
        |=> decOp == OP_LOAD_ACC_IMMEDIATE && !memRead && !indirectMode
        && immValue == $past(instrWord[7:0]))
        else $error("immediate load touched memory");
    a_shift_load:
    assert property (instrValid && instrWord[15:12] == 4'h2
        |=> decOp == OP_LOAD_ACC_SHIFTED && memRead
        && shiftCode == $past(instrWord[11:8]))
        else $error("shifted load decoded wrongly");
    a_store_high:
    assert property (instrValid && instrWord[15:11] == 5'h0b
        |=> decOp == OP_STORE_ACC_HIGH && memWrite
        && storeShift == $past(instrWord[10:8]))
        else $error("high store decoded wrongly");
    a_and_op:
    assert property (instrValid && instrWord[15:8] == 8'h79
        |=> decOp == OP_AND && memRead)
        else $error("logic AND decoded wrongly");
    a_one_cycle:
    assert property (decValid |-> cycleCount == CYC_ONE
        && wordCount == WORDS_ONE)
        else $error("cycle or word count not one");
endmodule // dsp_decoder_sva

bind dsp_accum_auxreg_decoder dsp_decoder_sva dsp_decoder_sva_inst (
    .clock(clock), .rst_b(rst_b), .instrValid(instrValid),
    .instrWord(instrWord), .decValid(decValid), .otherValid(otherValid),
    .decOp(decOp), .dataAddr(dataAddr), .memRead(memRead),
    .memWrite(memWrite), .indirectMode(indirectMode),
    .shiftCode(shiftCode), .storeShift(storeShift), .immValue(immValue),
    .cycleCount(cycleCount), .wordCount(wordCount),
    .auxPointer(auxPointer), .pagePointer(pagePointer));

// >>> test/dsp_accum_auxreg_decoder_test.sv
// Purpose: directed bench for the accumulator and aux decoder
// Assumes: outputs one edge after input
// Notes:   table words run back to back
`timescale 1ns/1ps

module dsp_accum_auxreg_decoder_test;
    import dsp_decode_pkg::*;
    // ----------------------------------------
    // Signals and opcode table
    // ----------------------------------------
    logic clock, rst_b, instrValid, operandValid, psel, penable, pwrite;
    logic [15:0] instrWord, operandData, storeAuxData, otherWord;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdData;
    logic decValid, memRead, memWrite, indirectMode, unsignedExt;
    logic accHigh, accLow, otherValid, auxPointer, pagePointer;
    logic pready, pslverr, rdErr;
    op_e decOp;
    logic [7:0] dataAddr, immValue;
    logic [SHIFT_W-1:0] shiftCode;
    logic [STSHIFT_W-1:0] storeShift;
    logic [PORT_W-1:0] portAddr;
    logic [1:0] cycleCount, wordCount;
    int failures = 0;
    int checksDone = 0;
    localparam int N = 24;
    // Flags per word: {other group, read, write, unsigned}
    logic [15:0] words [N] = '{16'h0305, 16'h1305, 16'h2305, 16'h6005,
        16'h6105, 16'h6205, 16'h6305, 16'h6405, 16'h6505, 16'h6605,
        16'h7805, 16'h7905, 16'h7a05, 16'h7f88, 16'h7f89, 16'h7e12,
        16'h5b05, 16'h5005, 16'h3105, 16'h7112, 16'h6805, 16'hf000,
        16'h7f8a, 16'h6700};
    op_e ops [N] = '{OP_ADD, OP_SUB, OP_LOAD_ACC_SHIFTED, OP_ADD_HIGH_HALF,
        OP_ADD_UNSIGNED_EXT, OP_SUBTRACT_HIGH_HALF, OP_SUBTRACT_UNSIGNED_EXT,
        OP_CONDITIONAL_SUBTRACT, OP_CLEAR_LOAD_HIGH, OP_CLEAR_LOAD_LOW,
        OP_XOR, OP_AND, OP_OR, OP_ABS, OP_CLEAR_ACC, OP_LOAD_ACC_IMMEDIATE,
        OP_STORE_ACC_HIGH, OP_STORE_ACC_LOW, OP_STORE_AUX_REG,
        OP_LOAD_AUX_IMMEDIATE, OP_MODIFY_AUX_REG, OP_OTHER, OP_OTHER,
        OP_OTHER};
    logic [3:0] fl [N] = '{4'h4, 4'h4, 4'h4, 4'h4, 4'h5, 4'h4, 4'h5, 4'h4,
        4'h4, 4'h5, 4'h4, 4'h4, 4'h4, 4'h0, 4'h0, 4'h0, 4'h2, 4'h2, 4'h2,
        4'h0, 4'h0, 4'h8, 4'h8, 4'h8};

    dsp_accum_auxreg_decoder dsp_accum_auxreg_decoder_inst (
        .clock(clock), .rst_b(rst_b), .instrValid(instrValid),
        .instrWord(instrWord), .operandValid(operandValid),
        .operandData(operandData), .decValid(decValid), .decOp(decOp),
        .dataAddr(dataAddr), .memRead(memRead), .memWrite(memWrite),
        .indirectMode(indirectMode), .shiftCode(shiftCode),
        .storeShift(storeShift), .portAddr(portAddr), .immValue(immValue),
        .unsignedExt(unsignedExt), .accHigh(accHigh), .accLow(accLow),
        .storeAuxData(storeAuxData), .cycleCount(cycleCount),
        .wordCount(wordCount), .otherValid(otherValid),
        .otherWord(otherWord), .auxPointer(auxPointer),
        .pagePointer(pagePointer), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // 200 MHz core clock
    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic give_verdict;
        $display("Checks %0d, failures %0d", checksDone, failures);
        if (failures == 0 && checksDone > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checksDone++;
        if (g !== e)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1)
        begin
            chk("pready", 1, pready);
            give_verdict();
        end
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk("prdata", e, rdData);
    endtask

    // One word, outputs looked at just after the answering edge
    task automatic send(input logic [15:0] w);
        @(posedge clock);
        instrValid <= 1'b1;
        instrWord <= w;
        @(posedge clock);
        instrValid <= 1'b0;
        #1;
    endtask

    task automatic operand(input logic [15:0] d);
        @(posedge clock);
        operandValid <= 1'b1;
        operandData <= d;
        @(posedge clock);
        operandValid <= 1'b0;
        #1;
    endtask

    task automatic tbl(input int i);
        chk("decOp", ops[i], decOp);
        chk("memRW", fl[i][2:1], {memRead, memWrite});
        chk("vld", {fl[i][3], !fl[i][3]}, {otherValid, decValid});
        chk("extHL", {fl[i][0], i inside {3, 5, 8, 16}, i inside {9, 17}},
            {unsignedExt, accHigh, accLow});
        chk("otherWord", words[i], otherWord);
        chk("cycles", fl[i][3] ? 2'h0 : CYC_ONE, cycleCount);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        rst_b = 1'b0;
        instrValid = 1'b0;
        instrWord = 16'h0;
        operandValid = 1'b0;
        operandData = 16'h0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        repeat (6) @(posedge clock);
        rst_b <= 1'b1;
        // Reset values, read-only and unmapped places
        rdchk(OFF_AUX1, 32'h0);
        rdchk(OFF_PTRS, 32'h0);
        apb(1'b1, OFF_LAST, 32'hffff_ffff);
        rdchk(OFF_LAST, 32'h0);
        rdchk(12'h010, 32'h0);
        chk("pslverr", 1, rdErr);
        // Indirect address, step and pointer change
        apb(1'b1, OFF_AUX0, 32'h1234);
        apb(1'b1, OFF_AUX1, 32'h00ab);
        send(16'h00a8);
        chk("addr", {1'b1, 8'h34}, {indirectMode, dataAddr});
        send(16'h0081);
        chk("addrPtr", {8'h35, 1'b1}, {dataAddr, auxPointer});
        send(16'h1098);
        chk("dataAddr", 8'hab, dataAddr);
        rdchk(OFF_AUX0, 32'h1235);
        rdchk(OFF_AUX1, 32'h00aa);
        // Immediate pointer loads, then paged direct address
        send(16'h6880);
        chk("auxPointer", 0, auxPointer);
        send(16'h6e01);
        chk("pagePointer", 1, pagePointer);
        send(16'h0305);
        chk("dataAddr", 8'h85, dataAddr);
        chk("shiftPort", 7'h1b, {shiftCode, portAddr});
        send(16'h7e85);
        chk("imm", 10'h085, {indirectMode, memRead, immValue});
        // Aux and page loads that wait for a memory word
        send(16'h3905);
        chk("memRead", 1, memRead);
        operand(16'h5a5a);
        rdchk(OFF_AUX1, 32'h5a5a);
        send(16'h3105);
        chk("storeAuxData", 16'h5a5a, storeAuxData);
        send(16'h6f05);
        chk("memRead", 1, memRead);
        operand(16'h0000);
        chk("pagePointer", 0, pagePointer);
        // Whole opcode table, one word per cycle
        for (int i = 0; i <= N; i++)
        begin
            @(posedge clock);
            instrValid <= (i < N);
            instrWord <= words[i % N];
            #1;
            if (i > 0)
                tbl(i - 1);
        end
        give_verdict();
    end
endmodule // dsp_accum_auxreg_decoder_test
